/* File: core/seec_regs.vh */
// Purpose: Constants for the serial EEPROM command front end.
// Assumes: Included by the EEPROM front-end design file; the FIFO design file does not include it.
// Notes: Opcodes are the two bits that follow the leading one bit.
`ifndef SEEC_REGS_VH
`define SEEC_REGS_VH
`define SEEC_OP_EXT 2'h0
`define SEEC_OP_WRITE 2'h1
`define SEEC_OP_READ 2'h2
`define SEEC_OP_ERASE 2'h3
`define SEEC_EXT_DIS 2'h0
`define SEEC_EXT_FILL 2'h1
`define SEEC_EXT_ERASE 2'h2
`define SEEC_EXT_EN 2'h3
`define SEEC_ST_IDLE 3'h0
`define SEEC_ST_OPC 3'h1
`define SEEC_ST_ADDR 3'h2
`define SEEC_ST_DATA 3'h3
`define SEEC_ST_READ 3'h4
`define SEEC_ST_DONE 3'h5
`define SEEC_PROG_CYCLES 32'd400000
`define SEEC_FIFO_DEPTH 4
`endif

/* File: core/seec_fifo.v */
// Purpose: Small FIFO for words bound for the array programmer.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Depth must be a power of two.
`timescale 1ns/1ps
module seec_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire mclk,
	input wire rst_n,
	input wire inValid,
	output wire inReady,
	input wire [WIDTH-1:0] inData,
	output wire outValid,
	input wire outReady,
	output wire [WIDTH-1:0] outData
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0] wrPtr;
	reg [AW:0] rdPtr;
	wire full;
	wire empty;
	assign empty = (wrPtr == rdPtr);
	assign full = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
	assign inReady = !full;
	assign outValid = !empty;
	assign outData = mem[rdPtr[AW-1:0]];
	always @(posedge mclk)
	begin
		if (inValid && !full)
			mem[wrPtr[AW-1:0]] <= inData;
	end
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wrPtr <= {(AW+1){1'b0}};
			rdPtr <= {(AW+1){1'b0}};
		end
		else
		begin
			if (inValid && !full)
				wrPtr <= wrPtr + 1'b1;
			if (outValid && outReady)
				rdPtr <= rdPtr + 1'b1;
		end
	end
endmodule // seec_fifo

/* File: core/seec_eeprom.v */
// Purpose: Command front end of a three-wire serial EEPROM with its array.
// Assumes: mclk far faster than the serial clock; pins pass two flip-flops.
// Notes: Array size set by ADDR_BITS (word-16 address width).
// Functional notes
// - Start is first sampled chip select and serial_in high
// - Nothing launches before a start bit
// - Chip select high leaves standby immediately
// - Execute only after every required bit arrives
// - After last bit ignore clock until start
// - Input bits sampled on serial clock rising edge
// - Output high-impedance except read data or status
// - Status low while busy, high when ready
// - Chip select fall releases the output
// - Word width select picks 16 or 8 bits
// - Power-up is programming disabled
// - Read gives a zero then word, MSB first
// - Read bits change on serial clock rise
// - Chip select high continues sequential read
// - Opcodes 10 read, 01 write, 11 erase, 00 extended
// - Address width follows array size and organisation
// - Writes take data; programming ops report status
// - Enable persists until disable; reads always work
// - Programming starts on chip select falling edge
// - Erase sets ones; fill erases then writes all
// - Status shows when select rises during programming
`timescale 1ns/1ps
`include "seec_regs.vh"
module seec_eeprom #(
	parameter ADDR_BITS = 7,
	parameter PROG_CYCLES = `SEEC_PROG_CYCLES
) (
	input wire mclk,
	input wire rst_n,
	input wire chipSelect,
	input wire serialClk,
	input wire serialIn,
	input wire wordWidthSelect,
	output reg serialOut,
	output wire serialOutEn_n,
	output wire readyBusyFlag,
	output wire programEnabled
);
	localparam WORDS = 1 << ADDR_BITS;
	localparam BYTE_AW = ADDR_BITS + 1;
	// Array stored as bytes so both organisations share one memory.
	reg [7:0] mem [0:2*WORDS-1];
	reg [1:0] csSync;
	reg [1:0] clkSync;
	reg [1:0] diSync;
	reg clkLast;
	reg csLast;
	wire cs;
	wire di;
	wire clkRise;
	wire csFall;
	wire csRise;
	assign cs = csSync[1];
	assign di = diSync[1];
	assign clkRise = clkSync[1] && !clkLast;
	assign csFall = csLast && !cs;
	assign csRise = !csLast && cs;
	reg [2:0] state;
	reg [1:0] opcode;
	reg [BYTE_AW-1:0] addr;
	reg [15:0] dataIn;
	reg [4:0] bitCnt;
	reg [15:0] shiftOut;
	reg driveOut;
	reg statusShow;
	reg pendOp;
	reg [1:0] pendKind;
	reg [BYTE_AW-1:0] pendAddr;
	reg enabled;
	reg busy;
	reg [31:0] progCnt;
	reg orgLatch;
	reg [1:0] orgSync;
	wire wide = orgSync[1];
	wire [4:0] addrLen;
	wire [4:0] dataLen;
	wire [BYTE_AW-1:0] addrNext;
	wire fifoInReady;
	wire fifoOutValid;
	wire [15:0] fifoOutData;
	reg fifoPop;
	localparam [4:0] WORD_AL = ADDR_BITS;
	localparam [4:0] BYTE_AL = BYTE_AW;
	assign addrLen = wide ? WORD_AL : BYTE_AL;
	assign dataLen = wide ? 5'h10 : 5'h08;
	assign addrNext = addr + 1'b1;
	assign serialOutEn_n = !(driveOut || statusShow);
	assign readyBusyFlag = !busy;
	assign programEnabled = enabled;
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			csSync <= 2'h0;
			clkSync <= 2'h0;
			diSync <= 2'h0;
			orgSync <= 2'h3;
			clkLast <= 1'b0;
			csLast <= 1'b0;
		end
		else
		begin
			csSync <= {csSync[0], chipSelect};
			clkSync <= {clkSync[0], serialClk};
			diSync <= {diSync[0], serialIn};
			orgSync <= {orgSync[0], wordWidthSelect};
			clkLast <= clkSync[1];
			csLast <= cs;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Instruction decoder, held in idle with output released while deselected; enable is kept.
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= `SEEC_ST_IDLE;
			opcode <= 2'h0;
			addr <= {BYTE_AW{1'b0}};
			dataIn <= 16'h0000;
			bitCnt <= 5'h00;
			shiftOut <= 16'h0000;
			driveOut <= 1'b0;
			serialOut <= 1'b0;
			pendOp <= 1'b0;
			pendKind <= 2'h0;
			pendAddr <= {BYTE_AW{1'b0}};
			enabled <= 1'b0;
			statusShow <= 1'b0;
			orgLatch <= 1'b1;
		end
		else if (!cs)
		begin
			state <= `SEEC_ST_IDLE;
			driveOut <= 1'b0;
			statusShow <= 1'b0;
			if (csFall && pendOp)
				pendOp <= 1'b0;
		end
		else
		begin
			if (csRise && busy)
			begin
				statusShow <= 1'b1;
				serialOut <= 1'b0;
			end
			if (statusShow)
				serialOut <= !busy;
			if (clkRise)
			begin
				case (state)
				`SEEC_ST_IDLE:
				begin
					if (di)
					begin
						state <= `SEEC_ST_OPC;
						bitCnt <= 5'h00;
						statusShow <= 1'b0;
						orgLatch <= wide;
					end
				end
				`SEEC_ST_OPC:
				begin
					opcode <= {opcode[0], di};
					bitCnt <= bitCnt + 5'h01;
					if (bitCnt == 5'h01)
					begin
						state <= `SEEC_ST_ADDR;
						bitCnt <= 5'h00;
					end
				end
				`SEEC_ST_ADDR:
				begin
					addr <= {addr[BYTE_AW-2:0], di};
					bitCnt <= bitCnt + 5'h01;
					if (bitCnt == addrLen - 5'h01)
					begin
						bitCnt <= 5'h00;
						case (opcode)
						`SEEC_OP_READ:
						begin
							state <= `SEEC_ST_READ;
							driveOut <= 1'b1;
							serialOut <= 1'b0;
						end
						`SEEC_OP_WRITE:
							state <= `SEEC_ST_DATA;
						`SEEC_OP_ERASE:
						begin
							state <= `SEEC_ST_DONE;
							pendOp <= enabled;
							pendKind <= `SEEC_OP_ERASE;
							pendAddr <= {addr[BYTE_AW-2:0], di};
						end
						default:
						begin
							state <= `SEEC_ST_DONE;
							case (wide ? addr[ADDR_BITS-2:ADDR_BITS-3]
								: addr[BYTE_AW-2:BYTE_AW-3])
							`SEEC_EXT_EN: enabled <= 1'b1;
							`SEEC_EXT_DIS: enabled <= 1'b0;
							`SEEC_EXT_ERASE:
							begin
								pendOp <= enabled;
								pendKind <= `SEEC_EXT_ERASE;
							end
							default:
							begin
								state <= `SEEC_ST_DATA;
								opcode <= `SEEC_OP_EXT;
							end
							endcase
						end
						endcase
					end
				end
				`SEEC_ST_DATA:
				begin
					dataIn <= {dataIn[14:0], di};
					bitCnt <= bitCnt + 5'h01;
					if (bitCnt == dataLen - 5'h01)
					begin
						state <= `SEEC_ST_DONE;
						pendOp <= enabled;
						// Fill is queued as the extended code so it cannot alias a write.
						pendKind <= (opcode == `SEEC_OP_WRITE) ? `SEEC_OP_WRITE : `SEEC_OP_EXT;
						pendAddr <= addr;
					end
				end
				`SEEC_ST_READ:
				begin
					if (bitCnt == 5'h00)
					begin
						serialOut <= wide ? mem[{addr[ADDR_BITS-1:0], 1'b0}][7]
							: mem[addr][7];
						shiftOut <= (wide
							? {mem[{addr[ADDR_BITS-1:0], 1'b0}], mem[{addr[ADDR_BITS-1:0], 1'b1}]}
							: {mem[addr], 8'h00}) << 1;
					end
					else
					begin
						serialOut <= shiftOut[15];
						shiftOut <= {shiftOut[14:0], 1'b0};
					end
					bitCnt <= bitCnt + 5'h01;
					if (bitCnt == dataLen - 5'h01)
					begin
						bitCnt <= 5'h00;
						addr <= wide ? {1'b0, addrNext[ADDR_BITS-1:0]} : addrNext;
					end
				end
				default:
					state <= `SEEC_ST_DONE;
				endcase
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Self-timed programmer; the FIFO carries the data word to it.
	seec_fifo #(
		.WIDTH(16),
		.DEPTH(`SEEC_FIFO_DEPTH),
		.AW(2)
	) uFifo (
		.mclk(mclk),
		.rst_n(rst_n),
		.inValid(csFall && pendOp && fifoInReady && !busy),
		.inReady(fifoInReady),
		.inData(dataIn),
		.outValid(fifoOutValid),
		.outReady(fifoPop),
		.outData(fifoOutData)
	);
	always @*
	begin
		fifoPop = fifoOutValid && busy && (progCnt == 32'd1);
	end
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busy <= 1'b0;
			progCnt <= 32'd0;
		end
		else if (csFall && pendOp && fifoInReady && !busy)
		begin
			busy <= 1'b1;
			progCnt <= PROG_CYCLES;
		end
		else if (busy)
		begin
			progCnt <= progCnt - 32'd1;
			if (progCnt == 32'd1)
				busy <= 1'b0;
		end
	end
	// array update at end of cycle
	integer i;
	always @(posedge mclk)
	begin
		if (fifoPop)
		begin
			for (i = 0; i < 2*WORDS; i = i + 1)
			begin
				if (pendKind == `SEEC_EXT_ERASE)
					mem[i] <= 8'hFF;
				else if (pendKind == `SEEC_OP_EXT)
					mem[i] <= orgLatch ? ((i % 2 == 0) ? fifoOutData[15:8]
						: fifoOutData[7:0]) : fifoOutData[7:0];
				else if (orgLatch && (i / 2 == pendAddr[ADDR_BITS-1:0]))
					mem[i] <= (pendKind == `SEEC_OP_ERASE) ? 8'hFF
						: ((i % 2 == 0) ? fifoOutData[15:8] : fifoOutData[7:0]);
				else if (!orgLatch && (i == pendAddr))
					mem[i] <= (pendKind == `SEEC_OP_ERASE) ? 8'hFF : fifoOutData[7:0];
			end
		end
	end
endmodule // seec_eeprom

/* File: verif/seec_eeprom_monitor.sv */
// Purpose: Port checker for the EEPROM front end.
// Assumes: Pins are synced with a lag of about 3 mclk.
// Notes: Bound to every seec_eeprom instance.
`timescale 1ns/1ps
module seec_eeprom_monitor #(
	parameter PROG_CYCLES = 20
) (
	input wire mclk,
	input wire rst_n,
	input wire chipSelect,
	input wire serialOut,
	input wire serialOutEn_n,
	input wire readyBusyFlag,
	input wire programEnabled
);
	int busyCnt;
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			busyCnt <= 0;
		else
			busyCnt <= readyBusyFlag ? 0 : busyCnt + 1;
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////
	reset_state_a: assert property ($rose(rst_n) |-> !programEnabled && serialOutEn_n)
		else $error("bad reset state");
	cs_release_a: assert property ($fell(chipSelect) |-> ##[1:5] serialOutEn_n)
		else $error("output not released");
	idle_hiz_a: assert property (!chipSelect [*6] |-> serialOutEn_n)
		else $error("driving while deselected");
	busy_low_a: assert property (!serialOutEn_n && !readyBusyFlag && $past(!readyBusyFlag, 4)
		|-> !serialOut)
		else $error("status high while busy");
	ready_high_a: assert property ($rose(readyBusyFlag) && chipSelect
		|-> ##[0:5] (serialOut || serialOutEn_n))
		else $error("status low when ready");
	enable_held_a: assert property ($changed(programEnabled) |-> $past(chipSelect, 4))
		else $error("enable moved unselected");
	busy_start_a: assert property ($fell(readyBusyFlag) |-> !chipSelect)
		else $error("busy before deselect");
	busy_length_a: assert property ($rose(readyBusyFlag)
		|-> busyCnt >= PROG_CYCLES - 1 && busyCnt <= PROG_CYCLES + 2)
		else $error("busy length wrong");
	cover property ($fell(readyBusyFlag));
	cover property ($rose(programEnabled));
	cover property (chipSelect && !serialOutEn_n && readyBusyFlag);
endmodule // seec_eeprom_monitor
bind seec_eeprom seec_eeprom_monitor #(.PROG_CYCLES(PROG_CYCLES)) mon_u (.mclk(mclk),
	.rst_n(rst_n), .chipSelect(chipSelect), .serialOut(serialOut),
	.serialOutEn_n(serialOutEn_n), .readyBusyFlag(readyBusyFlag),
	.programEnabled(programEnabled));

/* File: verif/seec_host_model.sv */
// Purpose: Host master on the three-wire serial bus.
// Assumes: Serial clock stands low outside frames.
// Notes: half sets the serial half period in mclk.
`timescale 1ns/1ps
module seec_host_model (
	input wire mclk,
	input wire serialOut,
	input wire serialOutEn_n,
	output logic chipSelect,
	output logic serialClk,
	output logic serialIn,
	output wire line
);
	int half = 8;
	// pins kept apart
	// A pull-up holds the wire high while the device lets go.
	assign line = serialOutEn_n ? 1'h1 : serialOut;
	initial
	begin
		chipSelect = 1'h0;
		serialClk = 1'h0;
		serialIn = 1'h0;
	end
	task automatic shift(input int n, input logic [63:0] bits, inout logic [63:0] got);
		got = 64'h0;
		for (int i = n - 1; i >= 0; i--)
		begin
			serialIn <= bits[i];
			repeat (half) @(posedge mclk);
			got = {got[62:0], line};
			serialClk <= 1'h1;
			repeat (half) @(posedge mclk);
			serialClk <= 1'h0;
		end
	endtask
	task automatic frame(input int n, input logic [63:0] bits, input int nr,
		inout logic [63:0] got);
		chipSelect <= 1'h1;
		repeat (half) @(posedge mclk);
		shift(n, bits, got);
		shift(nr, 64'h5555555555555555, got);
		chipSelect <= 1'h0;
		repeat (30) @(posedge mclk);
	endtask
	task automatic poll(inout int waited, inout logic first);
		chipSelect <= 1'h1;
		repeat (6) @(posedge mclk);
		first = line;
		for (waited = 0; !line && waited < 200; waited++)
			@(posedge mclk);
		chipSelect <= 1'h0;
		repeat (30) @(posedge mclk);
	endtask
endmodule // seec_host_model

/* File: verif/seec_eeprom_tb_top.sv */
// Purpose: Self-checking bench for the EEPROM front end.
// Assumes: Word address is 7 bits; programming lasts PROG mclk.
// Notes: Data comes from an 8-bit LFSR seeded with 92.
`timescale 1ns/1ps
module seec_eeprom_tb_top;
	localparam PROG = 60;
	logic mclk;
	logic rst_n;
	logic wordWidthSelect;
	logic [7:0] rnd;
	logic [63:0] got;
	logic [15:0] mem [0:127];
	logic [6:0] a;
	logic first;
	int waited;
	int fails;
	int comparisons;
	wire chipSelect, serialClk, serialIn, line;
	wire serialOut, serialOutEn_n, readyBusyFlag, programEnabled;
	seec_eeprom #(.ADDR_BITS(7), .PROG_CYCLES(PROG)) dut_u (.mclk(mclk), .rst_n(rst_n),
		.chipSelect(chipSelect), .serialClk(serialClk), .serialIn(serialIn),
		.wordWidthSelect(wordWidthSelect), .serialOut(serialOut),
		.serialOutEn_n(serialOutEn_n), .readyBusyFlag(readyBusyFlag),
		.programEnabled(programEnabled));
	seec_host_model host_u (.mclk(mclk), .serialOut(serialOut), .serialOutEn_n(serialOutEn_n),
		.chipSelect(chipSelect), .serialClk(serialClk), .serialIn(serialIn), .line(line));
	////////////////////////////////////////
	function automatic logic [7:0] step(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic prog(input int n, input logic [63:0] bits, input logic busy);
		host_u.frame(n, bits, 0, got);
		host_u.poll(waited, first);
		check("status", first, !busy);
		check("ready", waited < 200, 1);
	endtask
	task automatic rd(input logic [6:0] ra);
		host_u.frame(10, {1'h1, 2'h2, ra}, 33, got);
		check("read", got[32:0], {1'h0, mem[ra], mem[ra + 7'h1]});
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end
	initial
	begin
		repeat (100000) @(posedge mclk);
		fails++;
		report_and_stop;
	end
	initial
	begin
		rst_n = 1'h0;
		wordWidthSelect = 1'h1;
		rnd = 8'h5C;
		repeat (5) @(posedge mclk);
		rst_n <= 1'h1;
		repeat (4) @(posedge mclk);
		check("enable", programEnabled, 0);
		prog(26, {1'h1, 2'h1, 7'h05, 16'h0000}, 1'h0);
		host_u.frame(14, {4'h0, 1'h1, 2'h0, 7'h60}, 0, got);
		check("enable", programEnabled, 1);
		prog(10, {1'h1, 2'h0, 7'h40}, 1'h1);
		for (int i = 0; i < 128; i++)
			mem[i] = 16'hFFFF;
		for (int i = 0; i < 6; i++)
		begin
			rnd = step(rnd);
			a = (i == 0) ? 7'h7F : rnd[6:0];
			rnd = step(rnd);
			prog(26, {1'h1, 2'h1, a, rnd, a, 1'h1}, 1'h1);
			mem[a] = {rnd, a, 1'h1};
			rd(a);
		end
		prog(10, {1'h1, 2'h3, a}, 1'h1);
		mem[a] = 16'hFFFF;
		rd(a);
		prog(20, {1'h1, 2'h1, a, 10'h000}, 1'h0);
		rd(a);
		wordWidthSelect <= 1'h0;
		host_u.frame(11, {1'h1, 2'h2, 7'h7F, 1'h1}, 9, got);
		check("byte", got[8:0], {1'h0, mem[7'h7F][7:0]});
		wordWidthSelect <= 1'h1;
		prog(26, {1'h1, 2'h0, 7'h20, rnd, 8'hA5}, 1'h1);
		for (int i = 0; i < 128; i++)
			mem[i] = {rnd, 8'hA5};
		rd(7'h7F);
		host_u.frame(10, {1'h1, 2'h0, 7'h00}, 0, got);
		check("enable", programEnabled, 0);
		prog(10, {1'h1, 2'h3, 7'h10}, 1'h0);
		rd(7'h10);
		report_and_stop;
	end
endmodule // seec_eeprom_tb_top
